// File: hdl/async_serial_transceiver.v
/*
  Full-duplex asynchronous serial transceiver with four-word transmit and
  receive FIFOs, behind an Avalon-MM slave with one wait cycle per access.
  Assumes serial_in_pin is asynchronous and a single clock with enable.
*/
// What this block does
// - Format: 8 bit E/O/N or 9 bit; stop count
// - Reset gives 8 data, no parity, one stop
// - Loaded word shifts at next baud edge
// - Transmit FIFO nine wide, four deep, full flag
// - Write to full transmit FIFO is dropped
// - Reset clears both FIFOs
// - Transmit flag on move, or move leaving empty
// - Break holds line low, no transmit flag
// - Reading data pops and updates error flags
// - Receive FIFO four deep, avail flag, safe reads
// - Receive flag per select: each, three, four
// - Overrun when full; reception halts till cleared
// - Framing error on any zero stop bit
// - Parity error only with parity selected
// - Quiet flag low from start until stop
// - Break stores zero word, then waits high
// - Address mode flags every ninth-bit-set word
// - Loopback feeds receiver, pin ignored
// - Baud is clock over sixteen times N+1
// - Idle transmit line rests high
// - Disable empties FIFOs, clears overrun, allow and break, keeps setup and IRQ flags
`timescale 1ns/10ps
`default_nettype none
`include "uart_map.vh"

module async_serial_transceiver #(
  parameter DEPTH = 4
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire [4:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output reg waitrequest,
  input wire serial_in_pin,
  output reg serial_out_pin
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Bits in a frame including start and stop bits
  function [3:0] frame_len;
    input [1:0] fmt;
    input two_stop;
    begin
      frame_len = 4'h0 + 4'd10 + {3'h0, fmt != `FMT_8N} + {3'h0, two_stop};
    end
  endfunction

  function parity_of;
    input [1:0] fmt;
    input [7:0] d;
    begin
      parity_of = (fmt == `FMT_8O) ? ~^d : ^d;
    end
  endfunction

  // ----------------------------------------
  // Configuration and status state
  // ----------------------------------------
  reg module_on, loopback_on, stop_count_sel;
  reg [1:0] frame_format_sel;
  reg tx_irq_sel, tx_break_ctl, tx_allow, addr_detect_on;
  reg [1:0] rx_irq_sel;
  reg overrun_flag, tx_irq_flag, rx_irq_flag;
  reg [15:0] baud_divisor;

  reg [8:0] tx_fifo [0:DEPTH-1];
  reg [1:0] tx_wp, tx_rp;
  reg [2:0] tx_cnt;
  reg [10:0] rx_fifo [0:DEPTH-1];
  reg [1:0] rx_wp, rx_rp;
  reg [2:0] rx_cnt;

  wire tx_fifo_full = (tx_cnt == DEPTH);
  wire rx_avail = (rx_cnt != 3'h0);
  wire [10:0] rx_head = rx_fifo[rx_rp];

  // ----------------------------------------
  // Input synchroniser and baud prescaler
  // ----------------------------------------
  reg in_meta, in_sync;
  reg [15:0] pre;
  wire tick = (pre == baud_divisor);

  // ----------------------------------------
  // Transmit state
  // ----------------------------------------
  reg tx_busy;
  reg [3:0] tx_ph, tx_left;
  reg [11:0] tx_frame;
  reg tx_bit;
  wire tx_edge = tick && (tx_ph == 4'h0);
  wire tx_move = module_on && tx_allow && !tx_busy && (tx_cnt != 3'h0);
  wire [8:0] tx_word = tx_fifo[tx_rp];
  wire [8:0] tx_ninth = (frame_format_sel == `FMT_9N) ? {8'h00, tx_word[8]} :
    {8'h00, parity_of(frame_format_sel, tx_word[7:0])};
  // Unused high bits shift out as stop bits, so a short frame ends in ones
  wire [11:0] tx_build = (frame_format_sel == `FMT_8N) ?
    {3'h7, tx_word[7:0], 1'b0} : {2'h3, tx_ninth[0], tx_word[7:0], 1'b0};

  // ----------------------------------------
  // Receive state
  // ----------------------------------------
  localparam RX_IDLE = 2'h0;
  localparam RX_BITS = 2'h1;
  localparam RX_DONE = 2'h2;
  localparam RX_WAITHI = 2'h3;
  reg [1:0] rx_state;
  reg [3:0] rx_ph, rx_n;
  reg [11:0] rx_shifter;
  wire rx_line = loopback_on ? serial_out_pin : in_sync;
  wire rx_quiet = (rx_state == RX_IDLE) || (rx_state == RX_WAITHI);
  wire par_on = (frame_format_sel == `FMT_8E) || (frame_format_sel == `FMT_8O);
  wire [3:0] stop_pos = par_on || (frame_format_sel == `FMT_9N) ? 4'd10 : 4'd9;
  wire rx_framing_flag = !rx_shifter[stop_pos] ||
    (stop_count_sel && !rx_shifter[stop_pos + 4'h1]);
  wire rx_parity_flag = par_on &&
    (rx_shifter[9] != parity_of(frame_format_sel, rx_shifter[8:1]));
  wire [8:0] rx_word = (frame_format_sel == `FMT_9N) ? rx_shifter[9:1] :
    {1'b0, rx_shifter[8:1]};
  wire rx_push = (rx_state == RX_DONE) && (rx_cnt != DEPTH);
  wire [2:0] rx_cnt_after = rx_cnt + 3'h1;
  wire rx_irq_hit = (addr_detect_on && (frame_format_sel == `FMT_9N)) ? rx_word[8] :
    (rx_irq_sel[1] == 1'b0) ? 1'b1 :
    (rx_irq_sel[0] ? (rx_cnt_after == 3'h4) : (rx_cnt_after == 3'h3));

  // ----------------------------------------
  // Bus access decode
  // ----------------------------------------
  wire acc = (read || write) && !waitrequest;
  wire wr = write && !waitrequest;
  wire rd_pop = acc && read && (address == `OFS_RX_DATA) && rx_avail;
  wire tx_push = wr && (address == `OFS_TX_DATA) && !tx_fifo_full && module_on;
  wire clr_irq = wr && (address == `OFS_IRQ_FLAGS);
  wire [15:0] mode_rd = {module_on, 8'h00, loopback_on, 3'h0, frame_format_sel,
    stop_count_sel};
  wire [15:0] sta_rd = {tx_irq_sel, 3'h0, tx_break_ctl, tx_allow, tx_fifo_full,
    !tx_busy, rx_irq_sel, addr_detect_on, rx_quiet, rx_avail && rx_head[9],
    rx_avail && rx_head[10], overrun_flag, rx_avail};
  reg [31:0] rd_mux;
  // Last word popped; an empty FIFO reads this instead of an unwritten slot
  reg [8:0] rx_last;

  always @*
  begin
    case (address)
      `OFS_MODE_CTL: rd_mux = {16'h0000, mode_rd};
      `OFS_STATUS_CTL: rd_mux = {16'h0000, sta_rd};
      `OFS_RX_DATA: rd_mux = {23'h000000, rx_avail ? rx_head[8:0] : rx_last};
      `OFS_BAUD_DIV: rd_mux = {16'h0000, baud_divisor};
      `OFS_IRQ_FLAGS: rd_mux = {30'h00000000, rx_irq_flag, tx_irq_flag};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ----------------------------------------
  // Bus slave: one wait cycle, action at the released edge
  // ----------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
    end
    else if (ce)
    begin
      if ((read || write) && waitrequest)
      begin
        waitrequest <= 1'b0;
        readdata <= rd_mux;
      end
      else
        waitrequest <= 1'b1;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      module_on <= 1'b0;
      loopback_on <= 1'b0;
      frame_format_sel <= `RST_FMT;
      stop_count_sel <= `RST_STOP;
      tx_irq_sel <= 1'b0;
      tx_break_ctl <= 1'b0;
      tx_allow <= 1'b0;
      addr_detect_on <= 1'b0;
      rx_irq_sel <= 2'h0;
      baud_divisor <= `RST_BAUD;
    end
    else if (ce)
    begin
      if (wr && address == `OFS_MODE_CTL)
      begin
        module_on <= writedata[`MODE_ON_BIT];
        loopback_on <= writedata[`MODE_LOOP_BIT];
        frame_format_sel <= writedata[`MODE_FMT_HI:`MODE_FMT_LO];
        stop_count_sel <= writedata[`MODE_STOP_BIT];
      end
      if (wr && address == `OFS_STATUS_CTL)
      begin
        tx_irq_sel <= writedata[`STA_TXISEL_BIT];
        rx_irq_sel <= writedata[`STA_RXISEL_HI:`STA_RXISEL_LO];
        addr_detect_on <= writedata[`STA_ADDR_BIT];
        tx_break_ctl <= writedata[`STA_BRK_BIT] && module_on;
        tx_allow <= writedata[`STA_TXEN_BIT] && module_on;
      end
      if (wr && address == `OFS_BAUD_DIV)
        baud_divisor <= writedata[15:0];
      if (!module_on)
      begin
        tx_break_ctl <= 1'b0;
        tx_allow <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // FIFOs, flags and prescaler
  // ----------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_wp <= 2'h0;
      tx_rp <= 2'h0;
      tx_cnt <= 3'h0;
      rx_wp <= 2'h0;
      rx_rp <= 2'h0;
      rx_cnt <= 3'h0;
      rx_last <= 9'h000;
      overrun_flag <= 1'b0;
      tx_irq_flag <= 1'b0;
      rx_irq_flag <= 1'b0;
      pre <= 16'h0000;
      in_meta <= 1'b1;
      in_sync <= 1'b1;
    end
    else if (ce)
    begin
      in_meta <= serial_in_pin;
      in_sync <= in_meta;
      pre <= (!module_on || tick) ? 16'h0000 : pre + 16'h0001;
      if (tx_push)
      begin
        tx_fifo[tx_wp] <= writedata[8:0];
        tx_wp <= tx_wp + 2'h1;
      end
      if (tx_move)
        tx_rp <= tx_rp + 2'h1;
      tx_cnt <= tx_cnt + {2'h0, tx_push} - {2'h0, tx_move};
      if (rx_push)
      begin
        rx_fifo[rx_wp] <= {rx_framing_flag, rx_parity_flag, rx_word};
        rx_wp <= rx_wp + 2'h1;
      end
      if (rd_pop)
      begin
        rx_rp <= rx_rp + 2'h1;
        rx_last <= rx_head[8:0];
      end
      rx_cnt <= rx_cnt + {2'h0, rx_push} - {2'h0, rd_pop};
      // A new event wins over a clear in the same cycle
      if (wr && address == `OFS_STATUS_CTL && !writedata[`STA_OVERRUN_FLAG_BIT])
        overrun_flag <= 1'b0;
      if (rx_state == RX_DONE && rx_cnt == DEPTH)
        overrun_flag <= 1'b1;
      if (clr_irq && writedata[0])
        tx_irq_flag <= 1'b0;
      if (tx_move && (!tx_irq_sel || tx_cnt == 3'h1))
        tx_irq_flag <= 1'b1;
      if (clr_irq && writedata[1])
        rx_irq_flag <= 1'b0;
      if (rx_push && rx_irq_hit)
        rx_irq_flag <= 1'b1;
      if (!module_on)
      begin
        tx_wp <= 2'h0;
        tx_rp <= 2'h0;
        tx_cnt <= 3'h0;
        rx_wp <= 2'h0;
        rx_rp <= 2'h0;
        rx_cnt <= 3'h0;
        overrun_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_busy <= 1'b0;
      tx_ph <= 4'h0;
      tx_left <= 4'h0;
      tx_frame <= 12'hfff;
      tx_bit <= 1'b1;
      serial_out_pin <= 1'b1;
    end
    else if (ce)
    begin
      // Break overrides everything but does not stop the frame timing
      serial_out_pin <= !tx_break_ctl && tx_bit;
      if (!module_on || !tx_allow)
      begin
        tx_busy <= 1'b0;
        tx_ph <= 4'h0;
        tx_bit <= 1'b1;
      end
      else if (tx_move)
      begin
        tx_busy <= 1'b1;
        tx_frame <= tx_build;
        tx_left <= frame_len(frame_format_sel, stop_count_sel);
        tx_ph <= 4'h0;
      end
      else if (tx_busy && tick)
      begin
        tx_ph <= tx_ph + 4'h1;
        if (tx_edge)
        begin
          if (tx_left != 4'h0)
          begin
            tx_bit <= tx_frame[0];
            tx_frame <= {1'b1, tx_frame[11:1]};
            tx_left <= tx_left - 4'h1;
          end
          else
          begin
            tx_busy <= 1'b0;
            tx_bit <= 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_state <= RX_IDLE;
      rx_ph <= 4'h0;
      rx_n <= 4'h0;
      rx_shifter <= 12'h000;
    end
    else if (ce)
    begin
      if (!module_on)
        rx_state <= RX_IDLE;
      else
      begin
        case (rx_state)
          RX_IDLE:
            if (tick && !rx_line && !overrun_flag)
            begin
              rx_state <= RX_BITS;
              rx_ph <= 4'h0;
              rx_n <= 4'h0;
            end
          RX_BITS:
            if (tick)
            begin
              rx_ph <= rx_ph + 4'h1;
              if (rx_ph == `SAMPLE_POINT)
              begin
                rx_shifter[rx_n] <= rx_line;
                rx_n <= rx_n + 4'h1;
                if (rx_n == 4'h0 && rx_line)
                  rx_state <= RX_IDLE;
                else if (rx_n == frame_len(frame_format_sel, stop_count_sel) - 4'h1)
                  rx_state <= RX_DONE;
              end
            end
          RX_DONE:
            // A break leaves the line low: it must not pass for a start bit
            rx_state <= rx_framing_flag ? RX_WAITHI : RX_IDLE;
          RX_WAITHI:
            if (tick && rx_line)
              rx_state <= RX_IDLE;
          default:
            rx_state <= RX_IDLE;
        endcase
      end
    end
  end

endmodule // async_serial_transceiver
`default_nettype wire

// File: hdl/uart_map.vh
/*
  Register offsets, field positions and reset values of the serial transceiver.
  Assumes byte addressing on a 32-bit Avalon-MM slave, one register per word.
*/
`ifndef UART_MAP_VH
`define UART_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_MODE_CTL 5'h00
`define OFS_STATUS_CTL 5'h04
`define OFS_TX_DATA 5'h08
`define OFS_RX_DATA 5'h0c
`define OFS_BAUD_DIV 5'h10
`define OFS_IRQ_FLAGS 5'h14

// ----------------------------------------
// Mode control fields
// ----------------------------------------
`define MODE_ON_BIT 15
`define MODE_LOOP_BIT 6
`define MODE_FMT_HI 2
`define MODE_FMT_LO 1
`define MODE_STOP_BIT 0

// ----------------------------------------
// Status and control fields
// ----------------------------------------
`define STA_TXISEL_BIT 15
`define STA_BRK_BIT 11
`define STA_TXEN_BIT 10
`define STA_TXFULL_BIT 9
`define STA_TXEMPTY_BIT 8
`define STA_RXISEL_HI 7
`define STA_RXISEL_LO 6
`define STA_ADDR_BIT 5
`define STA_QUIET_BIT 4
`define STA_PARITY_FLAG_BIT 3
`define STA_FRAMING_FLAG_BIT 2
`define STA_OVERRUN_FLAG_BIT 1
`define STA_AVAIL_BIT 0

// ----------------------------------------
// Frame formats and reset values
// ----------------------------------------
`define FMT_8N 2'h0
`define FMT_8E 2'h1
`define FMT_8O 2'h2
`define FMT_9N 2'h3
`define RST_FMT 2'h0
`define RST_STOP 1'h0
`define RST_BAUD 16'h0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define OVERSAMPLE_LAST 4'hf
`define SAMPLE_POINT 4'h7

`endif

// File: verification/uart_props.sv
/* Checker for the serial transceiver: bus handshake and line timing.
   Sees only the top ports; ce is assumed high throughout. */
`timescale 1ns/10ps
`default_nettype none
`include "uart_map.vh"
module uart_props #(
  parameter DEPTH = 4
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire [4:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [31:0] readdata,
  input wire waitrequest,
  input wire serial_in_pin,
  input wire serial_out_pin
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic on, brk, brk_run;
  logic [15:0] baud;
  logic [31:0] low_len;
  wire acc = write && !waitrequest;
  wire rdok = read && !waitrequest;
  wire [20:0] bit_clks = {baud, 4'h0} + 21'h10;
  // ----
  // Shadow of what software wrote
  // ----
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      on <= 1'b0;
      brk <= 1'b0;
      baud <= 16'h0;
    end
    else if (acc && address == `OFS_MODE_CTL)
    begin
      on <= writedata[`MODE_ON_BIT];
      brk <= brk & writedata[`MODE_ON_BIT];
    end
    else if (acc && address == `OFS_STATUS_CTL)
      brk <= writedata[`STA_BRK_BIT] & on;
    else if (acc && address == `OFS_BAUD_DIV)
      baud <= writedata[15:0];
  end
  // Low runs marked if a break touched them, since those have no bit grid
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_len <= 32'h0;
      brk_run <= 1'b0;
    end
    else if (serial_out_pin)
    begin
      low_len <= 32'h0;
      brk_run <= brk;
    end
    else
    begin
      low_len <= low_len + 32'h1;
      brk_run <= brk_run | brk;
    end
  end
  sequence s_req;
    (read || write) && waitrequest && ce;
  endsequence
  a_wait_one: assert property (s_req |=> !waitrequest)
    else $error("no answer after one wait cycle");
  a_ack_single: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low twice");
  a_no_req_ack: assert property (!(read || write) |=> waitrequest)
    else $error("answer without request");
  a_unmapped_zero: assert property (rdok && address > `OFS_IRQ_FLAGS |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (rdok |-> readdata[31:16] == 16'h0)
    else $error("upper read bits set");
  a_baud_back: assert property (
    rdok && address == `OFS_BAUD_DIV |-> readdata[15:0] == baud)
    else $error("divisor readback wrong");
  a_off_idle: assert property ((!on) [*3] |-> serial_out_pin)
    else $error("line low while off");
  a_break_low: assert property (brk [*3] |-> !serial_out_pin)
    else $error("line high during break");
  a_bit_grid: assert property (
    $rose(serial_out_pin) && on && !brk_run |-> low_len % bit_clks == 32'h0)
    else $error("low run off the bit grid");
endmodule // uart_props
bind async_serial_transceiver uart_props #(.DEPTH(DEPTH)) chk (.clk(clk), .rst_n(rst_n),
  .ce(ce), .address(address), .read(read), .write(write), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .serial_in_pin(serial_in_pin),
  .serial_out_pin(serial_out_pin));
`default_nettype wire

// File: verification/serial_peer.sv
/* Remote serial node: sends whole frames, LSB first, and captures frames.
   Assumes a bit time of 16*(div+1) clocks, the same as the transceiver. */
`timescale 1ns/10ps
`default_nettype none
module serial_peer (
  input wire logic clk,
  input wire logic [15:0] div,
  input wire logic line_in,
  output logic line_out
);
  // ----
  // Line tasks
  // ----
  // Line rests at mark between frames
  initial line_out = 1'b1;
  task automatic send(input logic [12:0] v, input int n, input int gap);
    int i;
    for (i = 0; i < n; i++)
    begin
      line_out <= v[i];
      repeat (16 * (div + 1)) @(posedge clk);
    end
    line_out <= 1'b1;
    repeat (gap) @(posedge clk);
  endtask
  // Samples at mid-bit on the falling clock so the registered pin has settled
  task automatic grab(input int n, output logic [12:0] v);
    int i;
    v = 13'h1fff;
    for (i = 0; i < 4000 && line_in !== 1'b0; i++)
      @(negedge clk);
    repeat (8 * (div + 1)) @(negedge clk);
    for (i = 0; i < n; i++)
    begin
      if (i > 0)
        repeat (16 * (div + 1)) @(negedge clk);
      v[i] = line_in;
    end
  endtask
endmodule // serial_peer
`default_nettype wire

// File: verification/tb_top.sv
/* Self-checking bench: bus master tasks, remote node, random data.
   Assumes the register map header is on the include path. */
`timescale 1ns/10ps
`default_nettype none
`include "uart_map.vh"
module tb_top;
  localparam logic [4:0] MD = `OFS_MODE_CTL;
  localparam logic [4:0] ST = `OFS_STATUS_CTL;
  localparam logic [4:0] TX = `OFS_TX_DATA;
  localparam logic [4:0] RX = `OFS_RX_DATA;
  localparam logic [4:0] IQ = `OFS_IRQ_FLAGS;
  logic clk, rst_n, read, write;
  logic [4:0] address;
  logic [31:0] writedata, q;
  logic [15:0] div;
  logic [12:0] v, got;
  logic [8:0] d [0:5];
  int bad_count, samples_checked, seed, n, i;
  wire serial_in_pin, serial_out_pin, waitrequest;
  wire [31:0] readdata;
  async_serial_transceiver DUT (.clk(clk), .rst_n(rst_n), .ce(1'b1), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin));
  serial_peer peer (.clk(clk), .div(div), .line_in(serial_out_pin),
    .line_out(serial_in_pin));
  // ----
  // Helpers
  // ----
  task automatic wrap_up;
    if (bad_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] wd);
    int k;
    @(posedge clk);
    address <= a;
    writedata <= wd;
    write <= we;
    read <= !we;
    // Answer is taken at the rising edge itself, before the slave updates it
    @(posedge clk);
    for (k = 0; k < 50 && waitrequest !== 1'b0; k++)
      @(posedge clk);
    if (k == 50)
    begin
      bad_count++;
      wrap_up();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rc(input logic [4:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    check(nm, e, q);
  endtask
  task automatic tx_idle;
    int k;
    for (k = 0; k < 300; k++)
    begin
      bus(1'b0, ST, 32'h0);
      if (q[`STA_TXEMPTY_BIT] === 1'b1)
        return;
    end
    bad_count++;
    wrap_up();
  endtask
  function automatic logic [12:0] frm(input logic [1:0] fm, input logic [8:0] dv);
    logic [12:0] r;
    r = {4'hf, dv[7:0], 1'b0};
    if (fm == `FMT_9N)
      r[9] = dv[8];
    else if (fm == `FMT_8E)
      r[9] = ^dv[7:0];
    else if (fm == `FMT_8O)
      r[9] = ~^dv[7:0];
    return r;
  endfunction
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----
  // Main sequence
  // ----
  initial
  begin
    seed = 32'hbf1c;
    rst_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 5'h0;
    writedata = 32'h0;
    div = 16'h1;
    bad_count = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rc(MD, 32'h0, "mode");
    rc(ST, 32'h110, "status");
    rc(5'h18, 32'h0, "unmapped");
    bus(1'b1, `OFS_BAUD_DIV, 32'($random(seed)));
    rc(`OFS_BAUD_DIV, {16'h0, writedata[15:0]}, "baud");
    bus(1'b1, `OFS_BAUD_DIV, {16'h0, div});
    bus(1'b1, ST, 32'h400);
    rc(ST, 32'h110, "early allow");
    bus(1'b1, MD, 32'h8000);
    bus(1'b1, ST, 32'h400);
    for (i = 0; i < 8; i++)
    begin
      d[0] = 9'($random(seed));
      if (i[1:0] != `FMT_9N)
        d[0][8] = 1'b0;
      tx_idle();
      bus(1'b1, MD, {16'h0, 1'b1, 12'h0, i[1:0], i[2]});
      fork
        peer.grab(10 + int'(i[1:0] != 2'h0) + int'(i[2]), got);
        bus(1'b1, TX, {23'h0, d[0]});
      join
      check("frame", {19'h0, frm(i[1:0], d[0])}, {19'h0, got});
    end
    tx_idle();
    bus(1'b1, MD, 32'h8000);
    bus(1'b1, ST, 32'h8400);
    for (i = 0; i < 6; i++)
      d[i] = {1'b0, 8'($random(seed))};
    fork
      begin
        for (i = 0; i < 6; i++)
          bus(1'b1, TX, {23'h0, d[i]});
        rc(ST, 32'h8610, "full");
        bus(1'b1, IQ, 32'h1);
      end
      for (n = 0; n < 5; n++)
      begin
        peer.grab(10, got);
        check("fifo order", {19'h0, frm(`FMT_8N, d[n])}, {19'h0, got});
        if (n == 1)
          rc(IQ, 32'h0, "tx flag early");
      end
    join
    rc(IQ, 32'h1, "tx flag empty");
    bus(1'b1, MD, 32'h8002);
    for (n = 0; n < 3; n++)
    begin
      v = frm(`FMT_8E, d[n]);
      v[9] = v[9] ^ (n == 1);
      v[10] = (n != 2);
      peer.send(v, 11, 2 + 40 * n);
    end
    for (n = 0; n < 3; n++)
    begin
      rc(ST, 32'h8511 | (n == 1 ? 32'h8 : n == 2 ? 32'h4 : 32'h0), "rx flags");
      rc(RX, {23'h0, d[n]}, "rx data");
    end
    rc(ST, 32'h8510, "rx empty");
    rc(RX, {23'h0, d[2]}, "rx stale");
    bus(1'b1, MD, 32'h8000);
    bus(1'b1, ST, 32'h84c0);
    bus(1'b1, IQ, 32'h3);
    for (n = 0; n < 6; n++)
    begin
      peer.send(frm(`FMT_8N, d[n]), 10, 2);
      if (n == 2)
        rc(IQ, 32'h0, "rx flag three");
      if (n == 3)
        rc(IQ, 32'h2, "rx flag four");
    end
    rc(ST, 32'h85d3, "overrun");
    for (n = 0; n < 4; n++)
      rc(RX, {23'h0, d[n]}, "held data");
    bus(1'b1, ST, 32'h84c0);
    rc(ST, 32'h85d0, "overrun clear");
    bus(1'b1, MD, 32'h8040);
    fork
      peer.send(13'h0, 13, 2);
      peer.grab(10, got);
      bus(1'b1, TX, {23'h0, d[5]});
    join
    check("loop pin", {19'h0, frm(`FMT_8N, d[5])}, {19'h0, got});
    rc(RX, {23'h0, d[5]}, "loop data");
    bus(1'b1, MD, 32'h8046);
    bus(1'b1, ST, 32'h84e0);
    for (n = 0; n < 2; n++)
    begin
      bus(1'b1, IQ, 32'h3);
      bus(1'b1, TX, {23'h0, n[0], d[n][7:0]});
      tx_idle();
      rc(IQ, {30'h0, n[0], 1'b1}, "addr flag");
      rc(RX, {23'h0, n[0], d[n][7:0]}, "addr data");
    end
    bus(1'b1, MD, 32'h8000);
    bus(1'b1, IQ, 32'h3);
    bus(1'b1, ST, 32'hc00);
    repeat (14 * 16 * (div + 1)) @(posedge clk);
    check("break pin", 32'h0, {31'h0, serial_out_pin});
    bus(1'b1, ST, 32'h400);
    repeat (2 * 16 * (div + 1)) @(posedge clk);
    tx_idle();
    rc(IQ, 32'h0, "break flag");
    bus(1'b1, ST, 32'h84e0);
    bus(1'b1, TX, {23'h0, d[1]});
    bus(1'b1, MD, 32'h0);
    rc(ST, 32'h81f0, "disabled");
    rc(`OFS_BAUD_DIV, {16'h0, div}, "baud kept");
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
